// ==== core/fcsp_host_end.sv ====
// Host end of the flow controlled serial port
module fcsp_host_end #(
  parameter int unsigned BIT_CYC      = fcsp_pkg::BIT_CYC,
  parameter int unsigned BYTE_GAP_CYC = fcsp_pkg::BYTE_GAP_CYC,
  parameter int unsigned PKT_GAP_CYC  = fcsp_pkg::PKT_GAP_CYC,
  parameter int unsigned STROBE_CYC   = fcsp_pkg::STROBE_CYC
)(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  fcsp_link_if.host       link,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  input  wire logic       tx_diag,
  output logic            tx_taken,
  output logic            tx_drop,
  input  wire logic       rx_enable,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_end
);

  // ==========================================================================
  // Parameter checks
  if (BIT_CYC < 4 || STROBE_CYC < 1 || STROBE_CYC >= BIT_CYC || BYTE_GAP_CYC < 2 * BIT_CYC
      || PKT_GAP_CYC < 1)
  begin : g_chk
    $error("fcsp_host_end: timing parameters out of range");
  end

  // ==========================================================================
  // Pin synchronisers: line, request, accept-ready
  logic [2:0] s1_r, s2_r;
  logic       ma3_r;
  logic       mf_r;
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      s1_r  <= 3'h7;
      s2_r  <= 3'h7;
      ma3_r <= 1'b1;
      mf_r  <= 1'b0;
    end
    else
    begin
      s1_r  <= {link.mote_accept_ready_n, link.mote_send_request_n, link.mote_tx};
      s2_r  <= s1_r;
      ma3_r <= s2_r[2];
      mf_r  <= ma3_r && !s2_r[2];
    end
  end

  logic mote_fall;
  assign mote_fall = ma3_r && !s2_r[2];

  // ==========================================================================
  // Transmit path
  fcsp_pkg::fcsp_tx_t ts_r, ts_nxt;
  logic [9:0]  tsh_r, tsh_nxt;
  logic [3:0]  tbit_r, tbit_nxt;
  logic [31:0] tbaud_r, tbaud_nxt, tcnt_r, tcnt_nxt;
  logic        tlast_r, tlast_nxt, taken_r, taken_nxt, drop_r, drop_nxt;
  logic        start;

  always_comb
  begin
    ts_nxt    = ts_r;
    tsh_nxt   = tsh_r;
    tbit_nxt  = tbit_r;
    tbaud_nxt = tbaud_r;
    tcnt_nxt  = tcnt_r + 32'h0000_0001;
    tlast_nxt = tlast_r;
    taken_nxt = 1'b0;
    drop_nxt  = 1'b0;
    start     = 1'b0;
    if (tbit_r != 4'h0)
    begin
      if (tbaud_r == BIT_CYC - 1)
      begin
        tbaud_nxt = 32'h0000_0000;
        tsh_nxt   = {1'b1, tsh_r[9:1]};
        tbit_nxt  = tbit_r - 4'h1;
      end
      else
        tbaud_nxt = tbaud_r + 32'h0000_0001;
    end
    case (ts_r)
      fcsp_pkg::FCSP_TX_GAP:
        if (tcnt_r >= PKT_GAP_CYC - 1)
          ts_nxt = fcsp_pkg::FCSP_TX_IDLE;
      fcsp_pkg::FCSP_TX_IDLE:
        start = tx_valid && (tx_diag || s2_r[2] == fcsp_pkg::HS_ON);
      fcsp_pkg::FCSP_TX_SEND:
        if (tbit_r == 4'h0)
        begin
          tcnt_nxt = 32'h0000_0000;
          ts_nxt   = tlast_r ? fcsp_pkg::FCSP_TX_GAP : fcsp_pkg::FCSP_TX_ACK;
        end
      fcsp_pkg::FCSP_TX_ACK:
        // Ack may fall in the last cycle of the stop bit, so keep it one cycle
        if ((mote_fall || mf_r) && tx_valid)
          start = 1'b1;
        else if (tcnt_r >= BYTE_GAP_CYC - 1)
        begin
          drop_nxt = 1'b1;
          tcnt_nxt = 32'h0000_0000;
          ts_nxt   = fcsp_pkg::FCSP_TX_GAP;
        end
      default:
        ts_nxt = fcsp_pkg::FCSP_TX_GAP;
    endcase
    if (start)
    begin
      tsh_nxt   = fcsp_pkg::fcsp_frame(tx_data);
      tbit_nxt  = 4'hA;
      tbaud_nxt = 32'h0000_0000;
      tlast_nxt = tx_last;
      taken_nxt = 1'b1;
      ts_nxt    = fcsp_pkg::FCSP_TX_SEND;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ts_r    <= fcsp_pkg::FCSP_TX_GAP;
      tsh_r   <= 10'h3FF;
      tbit_r  <= 4'h0;
      tbaud_r <= 32'h0000_0000;
      tcnt_r  <= 32'h0000_0000;
      tlast_r <= 1'b0;
      taken_r <= 1'b0;
      drop_r  <= 1'b0;
    end
    else
    begin
      ts_r    <= ts_nxt;
      tsh_r   <= tsh_nxt;
      tbit_r  <= tbit_nxt;
      tbaud_r <= tbaud_nxt;
      tcnt_r  <= tcnt_nxt;
      tlast_r <= tlast_nxt;
      taken_r <= taken_nxt;
      drop_r  <= drop_nxt;
    end
  end

  // ==========================================================================
  // Receive path and host accept line
  fcsp_pkg::fcsp_rx_t rs_r, rs_nxt;
  logic [31:0] rbaud_r, rbaud_nxt, gcnt_r, gcnt_nxt, scnt_r, scnt_nxt;
  logic [7:0]  rsh_r, rsh_nxt, rdat_r, rdat_nxt;
  logic [2:0]  rbit_r, rbit_nxt;
  logic        rval_r, rval_nxt, rend_r, rend_nxt, inpkt_r, inpkt_nxt;
  logic        inrx_r, inrx_nxt, har_n_r, har_n_nxt;

  always_comb
  begin
    rs_nxt    = rs_r;
    rbaud_nxt = rbaud_r + 32'h0000_0001;
    rsh_nxt   = rsh_r;
    rbit_nxt  = rbit_r;
    rdat_nxt  = rdat_r;
    rval_nxt  = 1'b0;
    rend_nxt  = 1'b0;
    inpkt_nxt = inpkt_r;
    inrx_nxt  = inrx_r;
    gcnt_nxt  = gcnt_r + 32'h0000_0001;
    scnt_nxt  = (scnt_r != 32'h0000_0000) ? scnt_r - 32'h0000_0001 : scnt_r;
    case (rs_r)
      fcsp_pkg::FCSP_RX_IDLE:
      begin
        rbaud_nxt = 32'h0000_0000;
        if (s2_r[0] != fcsp_pkg::LINE_IDLE)
          rs_nxt = fcsp_pkg::FCSP_RX_START;
      end
      fcsp_pkg::FCSP_RX_START:
        if (rbaud_r >= BIT_CYC / 2 - 1)
        begin
          rbaud_nxt = 32'h0000_0000;
          rbit_nxt  = 3'h0;
          rs_nxt    = s2_r[0] ? fcsp_pkg::FCSP_RX_IDLE : fcsp_pkg::FCSP_RX_DATA;
        end
      fcsp_pkg::FCSP_RX_DATA:
        if (rbaud_r >= BIT_CYC - 1)
        begin
          rbaud_nxt = 32'h0000_0000;
          rsh_nxt   = {s2_r[0], rsh_r[7:1]};
          rbit_nxt  = rbit_r + 3'h1;
          if (rbit_r == 3'h7)
            rs_nxt = fcsp_pkg::FCSP_RX_STOP;
        end
      fcsp_pkg::FCSP_RX_STOP:
        if (rbaud_r >= BIT_CYC - 1)
        begin
          rs_nxt   = fcsp_pkg::FCSP_RX_IDLE;
          rval_nxt = s2_r[0];
          rdat_nxt = rsh_r;
        end
      default:
        rs_nxt = fcsp_pkg::FCSP_RX_IDLE;
    endcase
    if (!inrx_r)
    begin
      gcnt_nxt = 32'h0000_0000;
      // Answer a pending request only once the user is ready for it
      if (s2_r[1] == fcsp_pkg::HS_ON && rx_enable)
        inrx_nxt = 1'b1;
    end
    if (rval_nxt)
    begin
      inpkt_nxt = 1'b1;
      gcnt_nxt  = 32'h0000_0000;
      scnt_nxt  = STROBE_CYC;
    end
    else if (inrx_r && gcnt_r >= BYTE_GAP_CYC - 1)
    begin
      // Gap ends the packet; release accept unless a new request stands
      gcnt_nxt  = 32'h0000_0000;
      inpkt_nxt = 1'b0;
      rend_nxt  = inpkt_r;
      if (s2_r[1] == fcsp_pkg::HS_OFF)
        inrx_nxt = 1'b0;
    end
    if (!inrx_nxt || scnt_nxt != 32'h0000_0000)
      har_n_nxt = fcsp_pkg::HS_OFF;
    else
      har_n_nxt = fcsp_pkg::HS_ON;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      rs_r    <= fcsp_pkg::FCSP_RX_IDLE;
      rbaud_r <= 32'h0000_0000;
      gcnt_r  <= 32'h0000_0000;
      scnt_r  <= 32'h0000_0000;
      rsh_r   <= 8'h00;
      rdat_r  <= 8'h00;
      rbit_r  <= 3'h0;
      rval_r  <= 1'b0;
      rend_r  <= 1'b0;
      inpkt_r <= 1'b0;
      inrx_r  <= 1'b0;
      har_n_r <= 1'b1;
    end
    else
    begin
      rs_r    <= rs_nxt;
      rbaud_r <= rbaud_nxt;
      gcnt_r  <= gcnt_nxt;
      scnt_r  <= scnt_nxt;
      rsh_r   <= rsh_nxt;
      rdat_r  <= rdat_nxt;
      rbit_r  <= rbit_nxt;
      rval_r  <= rval_nxt;
      rend_r  <= rend_nxt;
      inpkt_r <= inpkt_nxt;
      inrx_r  <= inrx_nxt;
      har_n_r <= har_n_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign link.host_tx             = tsh_r[0];
  assign link.host_accept_ready_n = har_n_r;
  assign tx_taken                 = taken_r;
  assign tx_drop                  = drop_r;
  assign rx_data                  = rdat_r;
  assign rx_valid                 = rval_r;
  assign rx_end                   = rend_r;

endmodule

// ==== core/fcsp_link_if.sv ====
// Pins of the serial port between the mote and the host
interface fcsp_link_if;
  logic mote_tx;
  logic host_tx;
  logic mote_send_request_n;
  logic mote_accept_ready_n;
  logic host_accept_ready_n;

  modport mote
  (
    output mote_tx,
    output mote_send_request_n,
    output mote_accept_ready_n,
    input  host_tx,
    input  host_accept_ready_n
  );

  modport host
  (
    input  mote_tx,
    input  mote_send_request_n,
    input  mote_accept_ready_n,
    output host_tx,
    output host_accept_ready_n
  );
endinterface

// ==== core/fcsp_mote_end.sv ====
// Mote end of the flow controlled serial port
// How it works
// - 9600 bit/s, 8N1, full duplex both ways
// - All three handshake lines active low
// - Request low until host accepts or timeout
// - Host answers request by pulling accept low
// - Host strobes its accept after each byte
// - Host releases accept when packets are done
// - Accept ready low once network joined
// - Accept ready high without buffer or network
// - Accept ready may rise at critical moments
// - Host checks accept ready before network packets
// - Diagnostic packets accepted regardless of accept ready
// - Strobe accept ready for each following byte
// - After last byte return to level meaning
// - Host waits packet gap between packets
// - Diagnostic bytes strobed like network bytes
// - Response wait 500 ms, then drop packet
// - Packet gap is 20 ms
// - Byte gap over 7 ms discards, both idle
module fcsp_mote_end #(
  parameter int unsigned BIT_CYC       = fcsp_pkg::BIT_CYC,
  parameter int unsigned BYTE_GAP_CYC  = fcsp_pkg::BYTE_GAP_CYC,
  parameter int unsigned PKT_GAP_CYC   = fcsp_pkg::PKT_GAP_CYC,
  parameter int unsigned RESP_WAIT_CYC = fcsp_pkg::RESP_WAIT_CYC,
  parameter int unsigned STROBE_CYC    = fcsp_pkg::STROBE_CYC
)(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  fcsp_link_if.mote       link,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_taken,
  output logic            tx_drop,
  input  wire logic       net_joined,
  input  wire logic       buf_free,
  input  wire logic       crit_hold,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_end
);

  // ==========================================================================
  // Parameter checks
  if (BIT_CYC < 4 || STROBE_CYC < 1 || STROBE_CYC >= BIT_CYC || BYTE_GAP_CYC < 2 * BIT_CYC
      || PKT_GAP_CYC < 1 || RESP_WAIT_CYC < 1)
  begin : g_chk
    $error("fcsp_mote_end: timing parameters out of range");
  end

  // ==========================================================================
  // Pin synchronisers
  logic rx1_r, rx2_r, ha1_r, ha2_r, ha3_r, hf_r;
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      rx1_r <= 1'b1;
      rx2_r <= 1'b1;
      ha1_r <= 1'b1;
      ha2_r <= 1'b1;
      ha3_r <= 1'b1;
      hf_r  <= 1'b0;
    end
    else
    begin
      rx1_r <= link.host_tx;
      rx2_r <= rx1_r;
      ha1_r <= link.host_accept_ready_n;
      ha2_r <= ha1_r;
      ha3_r <= ha2_r;
      hf_r  <= ha3_r && !ha2_r;
    end
  end

  logic host_on, host_fall;
  assign host_on   = (ha2_r == fcsp_pkg::HS_ON);
  assign host_fall = ha3_r && !ha2_r;

  // ==========================================================================
  // Transmit path
  fcsp_pkg::fcsp_tx_t ts_r, ts_nxt;
  logic [9:0]  tsh_r, tsh_nxt;
  logic [3:0]  tbit_r, tbit_nxt;
  logic [31:0] tbaud_r, tbaud_nxt, tcnt_r, tcnt_nxt;
  logic        tlast_r, tlast_nxt, taken_r, taken_nxt, drop_r, drop_nxt, req_n_r, req_n_nxt;

  always_comb
  begin
    ts_nxt    = ts_r;
    tsh_nxt   = tsh_r;
    tbit_nxt  = tbit_r;
    tbaud_nxt = tbaud_r;
    tcnt_nxt  = tcnt_r + 32'h0000_0001;
    tlast_nxt = tlast_r;
    req_n_nxt = req_n_r;
    taken_nxt = 1'b0;
    drop_nxt  = 1'b0;
    // Shifting in ones keeps the line idle high between characters
    if (tbit_r != 4'h0)
    begin
      if (tbaud_r == BIT_CYC - 1)
      begin
        tbaud_nxt = 32'h0000_0000;
        tsh_nxt   = {1'b1, tsh_r[9:1]};
        tbit_nxt  = tbit_r - 4'h1;
      end
      else
        tbaud_nxt = tbaud_r + 32'h0000_0001;
    end
    case (ts_r)
      fcsp_pkg::FCSP_TX_GAP:
        if (tcnt_r >= PKT_GAP_CYC - 1)
          ts_nxt = fcsp_pkg::FCSP_TX_IDLE;
      fcsp_pkg::FCSP_TX_IDLE:
        if (tx_valid)
        begin
          req_n_nxt = fcsp_pkg::HS_ON;
          tcnt_nxt  = 32'h0000_0000;
          ts_nxt    = fcsp_pkg::FCSP_TX_REQ;
        end
      fcsp_pkg::FCSP_TX_REQ:
        if (host_on)
        begin
          req_n_nxt = fcsp_pkg::HS_OFF;
          tsh_nxt   = fcsp_pkg::fcsp_frame(tx_data);
          tbit_nxt  = 4'hA;
          tbaud_nxt = 32'h0000_0000;
          tlast_nxt = tx_last;
          taken_nxt = 1'b1;
          ts_nxt    = fcsp_pkg::FCSP_TX_SEND;
        end
        else if (tcnt_r >= RESP_WAIT_CYC - 1)
        begin
          req_n_nxt = fcsp_pkg::HS_OFF;
          drop_nxt  = 1'b1;
          tcnt_nxt  = 32'h0000_0000;
          ts_nxt    = fcsp_pkg::FCSP_TX_GAP;
        end
      fcsp_pkg::FCSP_TX_SEND:
        if (tbit_r == 4'h0)
        begin
          tcnt_nxt = 32'h0000_0000;
          ts_nxt   = tlast_r ? fcsp_pkg::FCSP_TX_GAP : fcsp_pkg::FCSP_TX_ACK;
        end
      fcsp_pkg::FCSP_TX_ACK:
        // Ack may fall in the last cycle of the stop bit, so keep it one cycle
        if ((host_fall || hf_r) && tx_valid)
        begin
          tsh_nxt   = fcsp_pkg::fcsp_frame(tx_data);
          tbit_nxt  = 4'hA;
          tbaud_nxt = 32'h0000_0000;
          tlast_nxt = tx_last;
          taken_nxt = 1'b1;
          ts_nxt    = fcsp_pkg::FCSP_TX_SEND;
        end
        else if (tcnt_r >= BYTE_GAP_CYC - 1)
        begin
          drop_nxt = 1'b1;
          tcnt_nxt = 32'h0000_0000;
          ts_nxt   = fcsp_pkg::FCSP_TX_GAP;
        end
      default:
      begin
        req_n_nxt = fcsp_pkg::HS_OFF;
        ts_nxt    = fcsp_pkg::FCSP_TX_GAP;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ts_r    <= fcsp_pkg::FCSP_TX_GAP;
      tsh_r   <= 10'h3FF;
      tbit_r  <= 4'h0;
      tbaud_r <= 32'h0000_0000;
      tcnt_r  <= 32'h0000_0000;
      tlast_r <= 1'b0;
      taken_r <= 1'b0;
      drop_r  <= 1'b0;
      req_n_r <= 1'b1;
    end
    else
    begin
      ts_r    <= ts_nxt;
      tsh_r   <= tsh_nxt;
      tbit_r  <= tbit_nxt;
      tbaud_r <= tbaud_nxt;
      tcnt_r  <= tcnt_nxt;
      tlast_r <= tlast_nxt;
      taken_r <= taken_nxt;
      drop_r  <= drop_nxt;
      req_n_r <= req_n_nxt;
    end
  end

  // ==========================================================================
  // Receive path and accept-ready line
  fcsp_pkg::fcsp_rx_t rs_r, rs_nxt;
  logic [31:0] rbaud_r, rbaud_nxt, gcnt_r, gcnt_nxt, scnt_r, scnt_nxt;
  logic [7:0]  rsh_r, rsh_nxt, rdat_r, rdat_nxt;
  logic [2:0]  rbit_r, rbit_nxt;
  logic        rval_r, rval_nxt, rend_r, rend_nxt, inpkt_r, inpkt_nxt, acc_n_r, acc_n_nxt;

  always_comb
  begin
    rs_nxt    = rs_r;
    rbaud_nxt = rbaud_r + 32'h0000_0001;
    rsh_nxt   = rsh_r;
    rbit_nxt  = rbit_r;
    rdat_nxt  = rdat_r;
    rval_nxt  = 1'b0;
    rend_nxt  = 1'b0;
    inpkt_nxt = inpkt_r;
    gcnt_nxt  = gcnt_r;
    scnt_nxt  = scnt_r;
    case (rs_r)
      fcsp_pkg::FCSP_RX_IDLE:
      begin
        rbaud_nxt = 32'h0000_0000;
        if (rx2_r != fcsp_pkg::LINE_IDLE)
          rs_nxt = fcsp_pkg::FCSP_RX_START;
      end
      fcsp_pkg::FCSP_RX_START:
        if (rbaud_r >= BIT_CYC / 2 - 1)
        begin
          rbaud_nxt = 32'h0000_0000;
          rbit_nxt  = 3'h0;
          rs_nxt    = rx2_r ? fcsp_pkg::FCSP_RX_IDLE : fcsp_pkg::FCSP_RX_DATA;
        end
      fcsp_pkg::FCSP_RX_DATA:
        if (rbaud_r >= BIT_CYC - 1)
        begin
          rbaud_nxt = 32'h0000_0000;
          rsh_nxt   = {rx2_r, rsh_r[7:1]};
          rbit_nxt  = rbit_r + 3'h1;
          if (rbit_r == 3'h7)
            rs_nxt = fcsp_pkg::FCSP_RX_STOP;
        end
      fcsp_pkg::FCSP_RX_STOP:
        if (rbaud_r >= BIT_CYC - 1)
        begin
          rs_nxt   = fcsp_pkg::FCSP_RX_IDLE;
          // A missing stop bit loses the character silently
          rval_nxt = rx2_r;
          rdat_nxt = rsh_r;
        end
      default:
        rs_nxt = fcsp_pkg::FCSP_RX_IDLE;
    endcase
    // Every byte, diagnostic or not, is acknowledged by a strobe
    if (rval_nxt)
    begin
      inpkt_nxt = 1'b1;
      gcnt_nxt  = 32'h0000_0000;
      scnt_nxt  = STROBE_CYC;
    end
    else
    begin
      if (scnt_r != 32'h0000_0000)
        scnt_nxt = scnt_r - 32'h0000_0001;
      if (inpkt_r)
      begin
        gcnt_nxt = gcnt_r + 32'h0000_0001;
        if (gcnt_r >= BYTE_GAP_CYC - 1)
        begin
          inpkt_nxt = 1'b0;
          rend_nxt  = 1'b1;
        end
      end
    end
    if (scnt_nxt != 32'h0000_0000)
      acc_n_nxt = fcsp_pkg::HS_OFF;
    else if (inpkt_nxt)
      acc_n_nxt = fcsp_pkg::HS_ON;
    else if (net_joined && buf_free && !crit_hold)
      acc_n_nxt = fcsp_pkg::HS_ON;
    else
      acc_n_nxt = fcsp_pkg::HS_OFF;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      rs_r    <= fcsp_pkg::FCSP_RX_IDLE;
      rbaud_r <= 32'h0000_0000;
      gcnt_r  <= 32'h0000_0000;
      scnt_r  <= 32'h0000_0000;
      rsh_r   <= 8'h00;
      rdat_r  <= 8'h00;
      rbit_r  <= 3'h0;
      rval_r  <= 1'b0;
      rend_r  <= 1'b0;
      inpkt_r <= 1'b0;
      acc_n_r <= 1'b1;
    end
    else
    begin
      rs_r    <= rs_nxt;
      rbaud_r <= rbaud_nxt;
      gcnt_r  <= gcnt_nxt;
      scnt_r  <= scnt_nxt;
      rsh_r   <= rsh_nxt;
      rdat_r  <= rdat_nxt;
      rbit_r  <= rbit_nxt;
      rval_r  <= rval_nxt;
      rend_r  <= rend_nxt;
      inpkt_r <= inpkt_nxt;
      acc_n_r <= acc_n_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign link.mote_tx             = tsh_r[0];
  assign link.mote_send_request_n = req_n_r;
  assign link.mote_accept_ready_n = acc_n_r;
  assign tx_taken                 = taken_r;
  assign tx_drop                  = drop_r;
  assign rx_data                  = rdat_r;
  assign rx_valid                 = rval_r;
  assign rx_end                   = rend_r;

endmodule

// ==== core/fcsp_pkg.sv ====
// Shared constants, state types and helpers of the flow controlled serial port
package fcsp_pkg;

  // ==========================================================================
  // Clock and character format
  localparam int unsigned CLK_KHZ    = 125000;
  localparam int unsigned BAUD_BPS   = 9600;
  localparam int unsigned DATA_BITS  = 8;
  localparam int unsigned FRAME_BITS = 10;
  localparam logic        LINE_IDLE  = 1'b1;
  localparam logic        HS_ON      = 1'b0;
  localparam logic        HS_OFF     = 1'b1;

  // ==========================================================================
  // Times in their own units
  localparam int unsigned BYTE_GAP_MS  = 7;
  localparam int unsigned PKT_GAP_MS   = 20;
  localparam int unsigned RESP_WAIT_MS = 500;
  localparam int unsigned STROBE_NS    = 500;

  // ==========================================================================
  // Times in clock cycles
  localparam int unsigned BIT_CYC       = CLK_KHZ * 1000 / BAUD_BPS;
  localparam int unsigned BYTE_GAP_CYC  = CLK_KHZ * BYTE_GAP_MS;
  localparam int unsigned PKT_GAP_CYC   = CLK_KHZ * PKT_GAP_MS;
  localparam int unsigned RESP_WAIT_CYC = CLK_KHZ * RESP_WAIT_MS;
  localparam int unsigned STROBE_CYC    = (STROBE_NS * CLK_KHZ + 999999) / 1000000;

  // ==========================================================================
  // State types
  typedef enum logic [4:0]
  {
    FCSP_TX_GAP  = 5'b00001,
    FCSP_TX_IDLE = 5'b00010,
    FCSP_TX_REQ  = 5'b00100,
    FCSP_TX_SEND = 5'b01000,
    FCSP_TX_ACK  = 5'b10000
  } fcsp_tx_t;

  typedef enum logic [3:0]
  {
    FCSP_RX_IDLE  = 4'b0001,
    FCSP_RX_START = 4'b0010,
    FCSP_RX_DATA  = 4'b0100,
    FCSP_RX_STOP  = 4'b1000
  } fcsp_rx_t;

  // ==========================================================================
  // Character framing: stop, data LSB first, start in bit 0
  function automatic logic [FRAME_BITS-1:0] fcsp_frame(input logic [DATA_BITS-1:0] d);
    fcsp_frame = {1'b1, d, 1'b0};
  endfunction

endpackage

// ==== verif/fcsp_link_chk.sv ====
// Assertions on the link pins between the two ends
module fcsp_link_chk #(
  parameter int unsigned BIT_CYC       = 16,
  parameter int unsigned RESP_WAIT_CYC = 2000
)(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic mote_tx,
  input wire logic host_tx,
  input wire logic mote_send_request_n,
  input wire logic mote_accept_ready_n,
  input wire logic host_accept_ready_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // Frame position: k at the k-th edge after the first low start sample
  int unsigned mc;
  int unsigned hc;
  int unsigned rc;
  function automatic int unsigned fpos(input int unsigned c, input logic line);
    if (c != 0)
      return (c == 10 * BIT_CYC - 1) ? 0 : c + 1;
    return line ? 0 : 1;
  endfunction
  always_ff @(posedge ref_clk)
  begin
    mc <= nrst ? fpos(mc, mote_tx) : 0;
    hc <= nrst ? fpos(hc, host_tx) : 0;
    rc <= (nrst && !mote_send_request_n) ? rc + 1 : 0;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ========
  // Pin checks
  a_reset_idle: assert property (disable iff (1'b0) !nrst |=>
    mote_tx && host_tx && mote_send_request_n && mote_accept_ready_n && host_accept_ready_n)
    else $error("link busy after reset");
  a_start_low: assert property (mc == BIT_CYC / 2 |-> !mote_tx)
    else $error("mote start bit high");
  a_mote_stop: assert property (mc == 9 * BIT_CYC + BIT_CYC / 2 |-> mote_tx)
    else $error("mote stop bit low");
  a_host_stop: assert property (hc == 9 * BIT_CYC + BIT_CYC / 2 |-> host_tx)
    else $error("host stop bit low");
  a_send_needs_ack: assert property (mc == 1 |-> !host_accept_ready_n)
    else $error("mote sent without host accept");
  a_req_release: assert property (!mote_send_request_n && !host_accept_ready_n
    |-> ##[1:4] mote_send_request_n) else $error("request held after accept");
  a_resp_limit: assert property (rc <= RESP_WAIT_CYC + 3)
    else $error("request held too long");
  a_host_byte_ack: assert property (mc == 9 * BIT_CYC |->
    ##[1:60] $rose(host_accept_ready_n)) else $error("host byte not acked");
  a_mote_byte_ack: assert property (hc == 9 * BIT_CYC && !mote_accept_ready_n
    |-> ##[1:60] $rose(mote_accept_ready_n)) else $error("mote byte not acked");
  a_strobe_width: assert property ($rose(host_accept_ready_n) |->
    host_accept_ready_n[*3]) else $error("host strobe short");
endmodule

// ==== verif/tb_flow_controlled_serial_port.sv ====
// Bench joining the mote end and the host end through one link
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module tb_flow_controlled_serial_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned BC = 16;
  localparam int unsigned BG = 400;
  localparam int unsigned PG = 200;
  localparam int unsigned RW = 2000;
  localparam int unsigned SC = 3;
  logic       ref_clk = 1'b0;
  logic       nrst    = 1'b0;
  logic [7:0] m_data  = 8'h00;
  logic       m_valid = 1'b0;
  logic       m_last  = 1'b0;
  logic [7:0] h_data  = 8'h00;
  logic       h_valid = 1'b0;
  logic       h_last  = 1'b0;
  logic       h_diag  = 1'b0;
  logic       rx_en   = 1'b1;
  logic       joined  = 1'b0;
  logic       free    = 1'b1;
  logic       crit    = 1'b0;
  logic       m_taken, m_drop, m_rxv, m_end, h_taken, h_rxv, h_end;
  logic [7:0] m_rx, h_rx;
  logic [7:0] mx[$], hr[$], hx[$], mr[$];
  int         errors = 0, checks = 0, cyc = 0, h_ends = 0, m_ends = 0, m_drops = 0;
  initial forever #4 ref_clk = ~ref_clk;
  fcsp_link_if lnk ();
  fcsp_mote_end #(.BIT_CYC(BC), .BYTE_GAP_CYC(BG), .PKT_GAP_CYC(PG), .RESP_WAIT_CYC(RW),
    .STROBE_CYC(SC)) fcsp_mote_end_i (.ref_clk(ref_clk), .nrst(nrst), .link(lnk.mote),
    .tx_data(m_data), .tx_valid(m_valid), .tx_last(m_last), .tx_taken(m_taken), .tx_drop(m_drop),
    .net_joined(joined), .buf_free(free), .crit_hold(crit), .rx_data(m_rx), .rx_valid(m_rxv),
    .rx_end(m_end));
  fcsp_host_end #(.BIT_CYC(BC), .BYTE_GAP_CYC(BG), .PKT_GAP_CYC(PG), .STROBE_CYC(SC))
    fcsp_host_end_i (.ref_clk(ref_clk), .nrst(nrst), .link(lnk.host), .tx_data(h_data),
    .tx_valid(h_valid), .tx_last(h_last), .tx_diag(h_diag), .tx_taken(h_taken), .tx_drop(),
    .rx_enable(rx_en), .rx_data(h_rx), .rx_valid(h_rxv), .rx_end(h_end));
  fcsp_link_chk #(.BIT_CYC(BC), .RESP_WAIT_CYC(RW)) fcsp_link_chk_i (.ref_clk(ref_clk),
    .nrst(nrst), .mote_tx(lnk.mote_tx), .host_tx(lnk.host_tx),
    .mote_send_request_n(lnk.mote_send_request_n), .mote_accept_ready_n(lnk.mote_accept_ready_n),
    .host_accept_ready_n(lnk.host_accept_ready_n));
  // ========
  // Expectations, drivers and monitors
  function automatic logic lvl(input logic [2:0] k);
    return (k[2] && k[1] && !k[0]) ? 1'b0 : 1'b1;
  endfunction
  function automatic logic [7:0] pick(input int i);
    return (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
  endfunction
  task automatic m_send(input int n, input bit fin);
    for (int i = 0; i < n; i++)
    begin
      m_data  <= pick(i);
      m_valid <= 1'b1;
      m_last  <= fin && (i == n - 1);
      do @(posedge ref_clk); while (m_taken !== 1'b1);
      mx.push_back(m_data);
    end
    m_valid <= 1'b0;
  endtask
  task automatic h_send(input int n, input bit diag);
    for (int i = 0; i < n; i++)
    begin
      h_data  <= pick(i);
      h_valid <= 1'b1;
      h_last  <= (i == n - 1);
      h_diag  <= diag;
      do @(posedge ref_clk); while (h_taken !== 1'b1);
      hx.push_back(h_data);
    end
    h_valid <= 1'b0;
  endtask
  task automatic cmp(ref logic [7:0] e[$], ref logic [7:0] g[$]);
    `CHK(g.size(), e.size())
    foreach (e[i]) if (i < g.size()) `CHK(g[i], e[i])
    e.delete();
    g.delete();
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard sized well above the longest sequence
  always @(posedge ref_clk)
  begin
    cyc++;
    if (h_rxv === 1'b1) hr.push_back(h_rx);
    if (m_rxv === 1'b1) mr.push_back(m_rx);
    if (h_end === 1'b1) h_ends++;
    if (m_end === 1'b1) m_ends++;
    if (m_drop === 1'b1) m_drops++;
    if (cyc == 20000)
    begin
      errors++;
      end_of_test();
    end
  end
  // ========
  // Tests
  initial
  begin
    int e0;
    void'($urandom(32'h6166958B));
    pause(2);
    nrst <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      {joined, free, crit} <= 3'(k);
      pause(4);
      `CHK(lnk.mote_accept_ready_n, lvl(3'(k)))
    end
    $display("test levels done");
    {joined, free, crit} <= 3'b110;
    pause(200);
    e0 = h_ends + m_ends;
    fork
      m_send(4, 1'b1);
      h_send(3, 1'b0);
    join
    wait (h_ends + m_ends == e0 + 2);
    cmp(mx, hr);
    cmp(hx, mr);
    `CHK(lnk.mote_accept_ready_n, 1'b0)
    $display("test duplex done");
    pause(250);
    joined <= 1'b0;
    pause(8);
    e0 = m_ends;
    h_send(3, 1'b1);
    wait (m_ends == e0 + 1);
    cmp(hx, mr);
    `CHK(lnk.mote_accept_ready_n, 1'b1)
    pause(250);
    fork h_send(2, 1'b0); join_none
    pause(300);
    `CHK(mr.size(), 0)
    joined <= 1'b1;
    wait (m_ends == e0 + 2);
    cmp(hx, mr);
    $display("test diagnostic done");
    pause(250);
    e0 = h_ends;
    m_send(2, 1'b0);
    wait (h_ends == e0 + 1);
    cmp(mx, hr);
    pause(100);
    `CHK(m_drops, 1)
    $display("test byte gap done");
    pause(250);
    e0 = cyc;
    rx_en   <= 1'b0;
    m_data  <= 8'h5A;
    m_last  <= 1'b1;
    m_valid <= 1'b1;
    wait (m_drops == 2);
    `CHK(cyc - e0 >= 2000, 1'b1)
    pause(2);
    m_valid <= 1'b0;
    `CHK(lnk.mote_send_request_n, 1'b1)
    `CHK(hr.size(), 0)
    $display("test no answer done");
    end_of_test();
  end
endmodule
